/* File: hdl/rate_conversion_core_pkg.sv */
`default_nettype none
package rate_conversion_core_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam logic [5:0] ADDR_RESERVED = 6'h00;
	localparam logic [5:0] ADDR_SYSTEM = 6'h01;
	localparam logic [5:0] ADDR_FILTER = 6'h02;
	localparam logic [5:0] ADDR_FORMAT = 6'h03;
	localparam logic [5:0] ADDR_LEFT = 6'h04;
	localparam logic [5:0] ADDR_RIGHT = 6'h05;
	localparam logic [5:0] ADDR_STEP = 6'h01;
	localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] SYS_MASK = 8'hdf;
	localparam logic [7:0] FLT_MASK = 8'h03;
	localparam logic [7:0] FMT_MASK = 8'hf7;
	localparam logic [7:0] ATTEN_MASK = 8'hff;
	localparam int SYS_PDN = 7;
	localparam int SYS_TRACK = 6;
	localparam int SYS_RSVD = 5;
	localparam int SYS_MUTE = 4;
	localparam int SYS_BYPASS = 3;
	localparam int SYS_MODE_HI = 2;
	localparam int FLT_DIRECT = 1;
	localparam int FLT_SHORT = 0;
	localparam int FMT_OWL_LSB = 6;
	localparam int FMT_OFMT_LSB = 4;
	localparam int FMT_RSVD = 3;
	localparam int FMT_IFMT_LSB = 0;
	localparam logic [6:0] DEPTH_NORMAL = 7'h40;
	localparam logic [6:0] DEPTH_SHORT = 7'h20;
	localparam logic [1:0] MODE_SLAVE = 2'h0;
	localparam logic [1:0] MODE_R128 = 2'h1;
	localparam logic [1:0] MODE_R512 = 2'h2;
	localparam logic [1:0] MODE_R256 = 2'h3;
	localparam logic [9:0] RATIO_NONE = 10'h000;
	localparam logic [9:0] RATIO_128 = 10'h080;
	localparam logic [9:0] RATIO_256 = 10'h100;
	localparam logic [9:0] RATIO_512 = 10'h200;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int REF_CLK_KHZ = 32'h0000_9c40;
	localparam int STARTUP_WAIT_US = 32'h0000_01f4;
	localparam int STARTUP_CYCLES = (STARTUP_WAIT_US * REF_CLK_KHZ + 999) / 1000;
	typedef enum logic [1:0] {
		FRAME_ADDR = 2'h0,
		FRAME_SKIP = 2'h1,
		FRAME_DATA = 2'h3,
		FRAME_IGNORE = 2'h2
	} frame_state_type;
endpackage
`default_nettype wire

/* File: hdl/spi_frame_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface spi_frame_if;
	logic wr_stb;
	logic [rate_conversion_core_pkg::ADDR_W-1:0] wr_addr;
	logic [rate_conversion_core_pkg::DATA_W-1:0] wr_data;
	logic accept_en;
	modport port (output wr_stb, output wr_addr, output wr_data, input accept_en);
	modport regs (input wr_stb, input wr_addr, input wr_data, output accept_en);
endinterface // spi_frame_if
`default_nettype wire

/* File: hdl/spi_write_port.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_write_port (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_cclk,
	input wire logic i_cdata,
	input wire logic i_cs_n,
	spi_frame_if.port frame
);
	logic cclk_s1_r, cclk_s2_r, cclk_s3_r;
	logic cdata_s1_r, cdata_s2_r;
	logic cs_n_s1_r, cs_n_s2_r;
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic [5:0] addr_r;
	logic wr_stb_r;
	logic [7:0] wr_data_r;
	logic [5:0] wr_addr_r;
	rate_conversion_core_pkg::frame_state_type state_r, state_nxt;
	wire cclk_rise;
	wire byte_done;
	wire [7:0] byte_in;
	wire addr_ok;
	wire data_byte;

	assign cclk_rise = cclk_s2_r & ~cclk_s3_r;
	assign byte_done = cclk_rise & ~cs_n_s2_r & (bit_cnt_r == rate_conversion_core_pkg::LAST_BIT);
	assign byte_in = {shift_r, cdata_s2_r};
	assign addr_ok = (byte_in[7:6] == rate_conversion_core_pkg::ADDR_TOP_ZERO) & frame.accept_en;
	assign data_byte = byte_done & (state_r == rate_conversion_core_pkg::FRAME_DATA);

	// Pin synchronisers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{cclk_s1_r, cclk_s2_r, cclk_s3_r} <= 3'h0;
			{cdata_s1_r, cdata_s2_r} <= 2'h0;
			{cs_n_s1_r, cs_n_s2_r} <= 2'h3;
		end else if (i_clk_en) begin
			{cclk_s1_r, cclk_s2_r, cclk_s3_r} <= {i_cclk, cclk_s1_r, cclk_s2_r};
			{cdata_s1_r, cdata_s2_r} <= {i_cdata, cdata_s1_r};
			{cs_n_s1_r, cs_n_s2_r} <= {i_cs_n, cs_n_s1_r};
		end
	end

	// Byte position within the frame
	always_comb begin
		state_nxt = state_r;
		if (cs_n_s2_r) begin
			state_nxt = rate_conversion_core_pkg::FRAME_ADDR;
		end else if (byte_done) begin
			case (state_r)
				rate_conversion_core_pkg::FRAME_ADDR: state_nxt = addr_ok ? rate_conversion_core_pkg::FRAME_SKIP : rate_conversion_core_pkg::FRAME_IGNORE;
				rate_conversion_core_pkg::FRAME_SKIP: state_nxt = rate_conversion_core_pkg::FRAME_DATA;
				rate_conversion_core_pkg::FRAME_DATA: state_nxt = rate_conversion_core_pkg::FRAME_DATA;
				default: state_nxt = rate_conversion_core_pkg::FRAME_IGNORE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= rate_conversion_core_pkg::FRAME_ADDR;
			bit_cnt_r <= 3'h0;
			shift_r <= 7'h00;
		end else if (i_clk_en) begin
			state_r <= state_nxt;
			if (cs_n_s2_r) begin
				bit_cnt_r <= 3'h0;
			end else if (cclk_rise) begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				shift_r <= byte_in[6:0];
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_r <= 6'h00;
			wr_stb_r <= 1'b0;
			wr_data_r <= 8'h00;
			wr_addr_r <= 6'h00;
		end else if (i_clk_en) begin
			wr_stb_r <= data_byte;
			if (byte_done && state_r == rate_conversion_core_pkg::FRAME_ADDR) begin
				addr_r <= byte_in[5:0];
			end else if (data_byte) begin
				addr_r <= addr_r + rate_conversion_core_pkg::ADDR_STEP;
			end
			if (data_byte) begin
				wr_data_r <= byte_in;
				wr_addr_r <= addr_r;
			end
		end
	end

	assign frame.wr_stb = wr_stb_r;
	assign frame.wr_data = wr_data_r;
	assign frame.wr_addr = wr_addr_r;

	property p_addr_step;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && data_byte) |=> (frame.wr_stb && addr_r == wr_addr_r + rate_conversion_core_pkg::ADDR_STEP);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address did not step after data byte");

	property p_bad_addr;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && byte_done && state_r == rate_conversion_core_pkg::FRAME_ADDR && !addr_ok) |=>
			(state_r == rate_conversion_core_pkg::FRAME_IGNORE);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("bad address byte not ignored");
endmodule // spi_write_port
`default_nettype wire

/* File: hdl/rate_conversion_core_control_registers.sv */
// Notes on behaviour
// - Power-down bit 0 idles core, keeps registers
// - Power-down bit 1 resumes with held settings
// - Tracking off: channels attenuated independently
// - Tracking on: left level drives both
// - Mute request is bit OR pin
// - Mute drives output to zero
// - Bypass request is bit OR pin
// - Bypass routes input straight to output
// - System bits 2..0 select port roles
// - Direct bit 0 selects decimation filter
// - Direct bit 1 downsamples without filtering
// - Short buffer bit: 64 or 32 samples
// - Format: word length, out, in fields
// - Left level resets zero, 0.5 dB steps
// - Right level resets zero, 0.5 dB steps
// - Tracking makes right use left level
// - Mode code gives master side and ratio
// - Bypass drops dither, attenuation and mute
// - Addresses 1..5 mapped, 0 reserved zero
// - Address, dummy byte, data, auto-increment
`timescale 1ns/10ps
`default_nettype none
module rate_conversion_core_control_registers #(
	parameter int STARTUP_CYCLES = rate_conversion_core_pkg::STARTUP_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_cclk,
	input wire logic i_cdata,
	input wire logic i_cs_n,
	input wire logic i_mute_pin,
	input wire logic i_bypass_pin,
	input wire logic i_sample_strobe,
	output logic o_spi_ready,
	output logic o_power_down,
	output logic [2:0] o_port_role_select,
	output logic o_in_port_master,
	output logic o_out_port_master,
	output logic [9:0] o_ref_clk_ratio,
	output logic o_direct_downsample_sel,
	output logic o_short_buffer_sel,
	output logic [6:0] o_buffer_depth,
	output logic [1:0] o_out_word_length,
	output logic [1:0] o_out_format,
	output logic [2:0] o_in_format,
	output logic [7:0] o_left_atten_level,
	output logic [7:0] o_right_atten_level,
	output logic o_soft_mute,
	output logic o_convert_skip,
	output logic o_dither_en
);
	localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	function automatic logic [7:0] clean(input logic [7:0] value, input logic [7:0] mask);
		return value & mask;
	endfunction

	function automatic logic [9:0] ratio_of(input logic [1:0] code);
		case (code)
			rate_conversion_core_pkg::MODE_R128: return rate_conversion_core_pkg::RATIO_128;
			rate_conversion_core_pkg::MODE_R512: return rate_conversion_core_pkg::RATIO_512;
			rate_conversion_core_pkg::MODE_R256: return rate_conversion_core_pkg::RATIO_256;
			default: return rate_conversion_core_pkg::RATIO_NONE;
		endcase
	endfunction

	spi_frame_if frame ();

	logic [CNT_W-1:0] cnt_r;
	logic ready_r;
	logic mute_s1_r, mute_s2_r;
	logic byp_s1_r, byp_s2_r;
	logic [7:0] sys_r, flt_r, fmt_r, left_r, right_r;
	logic skip_q_r, mute_q_r, dither_q_r;
	logic [7:0] left_q_r, right_q_r;
	logic [1:0] owl_q_r, ofmt_q_r;
	logic [2:0] ifmt_q_r;
	logic in_master_r, out_master_r, direct_r, short_r;
	logic [9:0] ratio_r;
	logic [6:0] depth_r;

	wire wr_sys;
	wire wr_flt;
	wire wr_fmt;
	wire wr_left;
	wire wr_right;
	wire mute_req;
	wire byp_req;
	wire track;
	wire [2:0] mode;
	wire mode_master;
	wire [7:0] right_sel;
	wire boundary;

	spi_write_port u_port (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_cclk(i_cclk),
		.i_cdata(i_cdata),
		.i_cs_n(i_cs_n),
		.frame(frame)
	);

	// Startup wait before the port accepts frames
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
			ready_r <= 1'b0;
		end else if (i_clk_en && !ready_r) begin
			if (cnt_r == CNT_LAST) begin
				ready_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r + CNT_ONE;
			end
		end
	end
	assign frame.accept_en = ready_r;

	// Pin synchronisers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{mute_s1_r, mute_s2_r} <= 2'h0;
			{byp_s1_r, byp_s2_r} <= 2'h0;
		end else if (i_clk_en) begin
			{mute_s1_r, mute_s2_r} <= {i_mute_pin, mute_s1_r};
			{byp_s1_r, byp_s2_r} <= {i_bypass_pin, byp_s1_r};
		end
	end

	// Address decode; address 0 and unused addresses take no write
	assign wr_sys = frame.wr_stb & (frame.wr_addr == rate_conversion_core_pkg::ADDR_SYSTEM);
	assign wr_flt = frame.wr_stb & (frame.wr_addr == rate_conversion_core_pkg::ADDR_FILTER);
	assign wr_fmt = frame.wr_stb & (frame.wr_addr == rate_conversion_core_pkg::ADDR_FORMAT);
	assign wr_left = frame.wr_stb & (frame.wr_addr == rate_conversion_core_pkg::ADDR_LEFT);
	assign wr_right = frame.wr_stb & (frame.wr_addr == rate_conversion_core_pkg::ADDR_RIGHT);

	// Register file, reserved bits forced to zero
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sys_r <= rate_conversion_core_pkg::RESET_VALUE;
			flt_r <= rate_conversion_core_pkg::RESET_VALUE;
			fmt_r <= rate_conversion_core_pkg::RESET_VALUE;
			left_r <= rate_conversion_core_pkg::RESET_VALUE;
			right_r <= rate_conversion_core_pkg::RESET_VALUE;
		end else if (i_clk_en) begin
			if (wr_sys) sys_r <= clean(frame.wr_data, rate_conversion_core_pkg::SYS_MASK);
			if (wr_flt) flt_r <= clean(frame.wr_data, rate_conversion_core_pkg::FLT_MASK);
			if (wr_fmt) fmt_r <= clean(frame.wr_data, rate_conversion_core_pkg::FMT_MASK);
			if (wr_left) left_r <= clean(frame.wr_data, rate_conversion_core_pkg::ATTEN_MASK);
			if (wr_right) right_r <= clean(frame.wr_data, rate_conversion_core_pkg::ATTEN_MASK);
		end
	end

	assign mute_req = sys_r[rate_conversion_core_pkg::SYS_MUTE] | mute_s2_r;
	assign byp_req = sys_r[rate_conversion_core_pkg::SYS_BYPASS] | byp_s2_r;
	assign track = sys_r[rate_conversion_core_pkg::SYS_TRACK];
	assign right_sel = track ? left_r : right_r;
	assign boundary = i_clk_en & i_sample_strobe;

	// Audio settings taken over only at a sample boundary
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			skip_q_r <= 1'b0;
			mute_q_r <= 1'b0;
			dither_q_r <= 1'b1;
			left_q_r <= rate_conversion_core_pkg::RESET_VALUE;
			right_q_r <= rate_conversion_core_pkg::RESET_VALUE;
			owl_q_r <= 2'h0;
			ofmt_q_r <= 2'h0;
			ifmt_q_r <= 3'h0;
		end else if (boundary) begin
			skip_q_r <= byp_req;
			mute_q_r <= mute_req & ~byp_req;
			dither_q_r <= ~byp_req;
			left_q_r <= byp_req ? rate_conversion_core_pkg::RESET_VALUE : left_r;
			right_q_r <= byp_req ? rate_conversion_core_pkg::RESET_VALUE : right_sel;
			owl_q_r <= fmt_r[rate_conversion_core_pkg::FMT_OWL_LSB +: 2];
			ofmt_q_r <= fmt_r[rate_conversion_core_pkg::FMT_OFMT_LSB +: 2];
			ifmt_q_r <= fmt_r[rate_conversion_core_pkg::FMT_IFMT_LSB +: 3];
		end
	end

	// Port role and filter decode
	assign mode = sys_r[rate_conversion_core_pkg::SYS_MODE_HI:0];
	assign mode_master = (mode[1:0] != rate_conversion_core_pkg::MODE_SLAVE);
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			in_master_r <= 1'b0;
			out_master_r <= 1'b0;
			ratio_r <= rate_conversion_core_pkg::RATIO_NONE;
			direct_r <= 1'b0;
			short_r <= 1'b0;
			depth_r <= rate_conversion_core_pkg::DEPTH_NORMAL;
		end else if (i_clk_en) begin
			in_master_r <= mode[2] & mode_master;
			out_master_r <= ~mode[2] & mode_master;
			ratio_r <= ratio_of(mode[1:0]);
			direct_r <= flt_r[rate_conversion_core_pkg::FLT_DIRECT];
			short_r <= flt_r[rate_conversion_core_pkg::FLT_SHORT];
			depth_r <= flt_r[rate_conversion_core_pkg::FLT_SHORT] ? rate_conversion_core_pkg::DEPTH_SHORT : rate_conversion_core_pkg::DEPTH_NORMAL;
		end
	end

	assign o_spi_ready = ready_r;
	assign o_power_down = ~sys_r[rate_conversion_core_pkg::SYS_PDN];
	assign o_port_role_select = mode;
	assign o_in_port_master = in_master_r;
	assign o_out_port_master = out_master_r;
	assign o_ref_clk_ratio = ratio_r;
	assign o_direct_downsample_sel = direct_r;
	assign o_short_buffer_sel = short_r;
	assign o_buffer_depth = depth_r;
	assign o_out_word_length = owl_q_r;
	assign o_out_format = ofmt_q_r;
	assign o_in_format = ifmt_q_r;
	assign o_left_atten_level = left_q_r;
	assign o_right_atten_level = right_q_r;
	assign o_soft_mute = mute_q_r;
	assign o_convert_skip = skip_q_r;
	assign o_dither_en = dither_q_r;

	property p_pdn_enter;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && wr_sys && !frame.wr_data[rate_conversion_core_pkg::SYS_PDN]) |=>
			(o_power_down && left_r == $past(left_r));
	endproperty
	a_pdn_enter: assert property (p_pdn_enter) else $error("power-down not entered or state lost");

	property p_pdn_leave;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && wr_sys && frame.wr_data[rate_conversion_core_pkg::SYS_PDN]) |=> !o_power_down;
	endproperty
	a_pdn_leave: assert property (p_pdn_leave) else $error("power-down not released");

	property p_mute;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(boundary && mute_req && !byp_req) |=> o_soft_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("mute request not applied");

	property p_mute_pin;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(boundary && !byp_req && !sys_r[rate_conversion_core_pkg::SYS_MUTE] && !mute_s2_r) |=> !o_soft_mute;
	endproperty
	a_mute_pin: assert property (p_mute_pin) else $error("mute set without request");

	property p_bypass;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(boundary && byp_req) |=>
			(o_convert_skip && !o_soft_mute && !o_dither_en && o_left_atten_level == 8'h00);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass effects wrong");

	property p_track;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(boundary && !byp_req && track) |=> (o_right_atten_level == o_left_atten_level);
	endproperty
	a_track: assert property (p_track) else $error("tracking not applied");

	property p_indep;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(boundary && !byp_req && !track) |=> (o_right_atten_level == $past(right_r));
	endproperty
	a_indep: assert property (p_indep) else $error("right level not independent");

	property p_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!boundary |=> ($stable(o_left_atten_level) && $stable(o_soft_mute) && $stable(o_out_format));
	endproperty
	a_hold: assert property (p_hold) else $error("audio setting changed off boundary");

	property p_depth;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en |=> (o_buffer_depth == ($past(flt_r[0]) ? rate_conversion_core_pkg::DEPTH_SHORT : rate_conversion_core_pkg::DEPTH_NORMAL));
	endproperty
	a_depth: assert property (p_depth) else $error("buffer depth wrong");

	property p_role;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && mode == 3'h6) |=> (o_in_port_master && !o_out_port_master && o_ref_clk_ratio == 10'h200);
	endproperty
	a_role: assert property (p_role) else $error("port role decode wrong");

	property p_reserved;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(!sys_r[rate_conversion_core_pkg::SYS_RSVD] && !fmt_r[rate_conversion_core_pkg::FMT_RSVD] && flt_r[7:2] == 6'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_left_write;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_clk_en && wr_left) |=> (left_r == $past(frame.wr_data));
	endproperty
	a_left_write: assert property (p_left_write) else $error("left level write lost");

	c_bypass: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) boundary && byp_req);
	c_track: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) boundary && track && !byp_req);
	c_burst: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) wr_left ##[1:400] wr_right);
	c_wake: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $fell(o_power_down));
endmodule // rate_conversion_core_control_registers
`default_nettype wire

/* File: verif/host_spi_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
	input wire logic i_ref_clk,
	output logic o_cs_n,
	output logic o_cclk,
	output logic o_cdata
);
	localparam int HALF_CYCLES = 4;

	initial begin
		o_cs_n = 1'b1;
		o_cclk = 1'b0;
		o_cdata = 1'b0;
	end

	task automatic wait_neg(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask

	// Address byte, dummy byte, then count data bytes (1 to 4, highest first), MSB first; clock idles low
	task automatic send_frame(input logic [7:0] addr, input logic [31:0] data, input int count);
		logic [47:0] frame_bits;
		frame_bits = {addr, 8'hff, data << (8 * (4 - count))};
		wait_neg(1);
		o_cs_n = 1'b0;
		wait_neg(HALF_CYCLES);
		for (int i = 0; i < 8 * (count + 2); i++) begin
			o_cdata = frame_bits[47];
			frame_bits = {frame_bits[46:0], 1'b0};
			wait_neg(HALF_CYCLES);
			o_cclk = 1'b1;
			wait_neg(HALF_CYCLES);
			o_cclk = 1'b0;
		end
		wait_neg(HALF_CYCLES);
		o_cs_n = 1'b1;
		// Released data line shows no stale value
		o_cdata = ~o_cdata;
		wait_neg(HALF_CYCLES);
	endtask
	// Callers pass data with reserved bits zero and keep decimation when slowing down
endmodule // host_spi_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end
module tb_top;
	localparam int TIMEOUT_CYCLES = 30000;
	logic i_ref_clk, i_rst_n, i_clk_en, i_cclk, i_cdata, i_cs_n;
	logic i_mute_pin, i_bypass_pin, i_sample_strobe;
	logic o_spi_ready, o_power_down, o_in_port_master, o_out_port_master;
	logic o_direct_downsample_sel, o_short_buffer_sel, o_soft_mute, o_convert_skip, o_dither_en;
	logic [2:0] o_port_role_select, o_in_format;
	logic [9:0] o_ref_clk_ratio;
	logic [6:0] o_buffer_depth;
	logic [1:0] o_out_word_length, o_out_format;
	logic [7:0] o_left_atten_level, o_right_atten_level;
	int num_errors = 0;
	int num_checks = 0;
	int cycle_count = 0;

	rate_conversion_core_control_registers #(.STARTUP_CYCLES(8)) DUT (
		.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_cclk(i_cclk),
		.i_cdata(i_cdata), .i_cs_n(i_cs_n), .i_mute_pin(i_mute_pin), .i_bypass_pin(i_bypass_pin),
		.i_sample_strobe(i_sample_strobe), .o_spi_ready(o_spi_ready), .o_power_down(o_power_down),
		.o_port_role_select(o_port_role_select), .o_in_port_master(o_in_port_master),
		.o_out_port_master(o_out_port_master), .o_ref_clk_ratio(o_ref_clk_ratio),
		.o_direct_downsample_sel(o_direct_downsample_sel), .o_short_buffer_sel(o_short_buffer_sel),
		.o_buffer_depth(o_buffer_depth), .o_out_word_length(o_out_word_length),
		.o_out_format(o_out_format), .o_in_format(o_in_format),
		.o_left_atten_level(o_left_atten_level), .o_right_atten_level(o_right_atten_level),
		.o_soft_mute(o_soft_mute), .o_convert_skip(o_convert_skip), .o_dither_en(o_dither_en)
	);

	host_spi_model host (.i_ref_clk(i_ref_clk), .o_cs_n(i_cs_n), .o_cclk(i_cclk), .o_cdata(i_cdata));

	initial begin
		i_ref_clk = 1'b0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		cycle_count++;
		if (cycle_count == TIMEOUT_CYCLES) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic settle();
		repeat (10) @(negedge i_ref_clk);
	endtask

	task automatic strobe();
		@(negedge i_ref_clk);
		i_sample_strobe = 1'b1;
		@(negedge i_ref_clk);
		i_sample_strobe = 1'b0;
	endtask

	task automatic t_reset_values();
		`CHECK(o_power_down, 1'b1)
		`CHECK(o_left_atten_level, 8'h00)
		`CHECK(o_right_atten_level, 8'h00)
		`CHECK(o_buffer_depth, rate_conversion_core_pkg::DEPTH_NORMAL)
		`CHECK(o_soft_mute, 1'b0)
		`CHECK(o_convert_skip, 1'b0)
		`CHECK(o_direct_downsample_sel, 1'b0)
		`CHECK(o_ref_clk_ratio, rate_conversion_core_pkg::RATIO_NONE)
	endtask

	task automatic t_port_modes();
		logic [9:0] ratio;
		for (int m = 0; m < 8; m++) begin
			host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0080 | 32'(m), 1);
			settle();
			case (m[1:0])
				2'd1: ratio = rate_conversion_core_pkg::RATIO_128;
				2'd2: ratio = rate_conversion_core_pkg::RATIO_512;
				2'd3: ratio = rate_conversion_core_pkg::RATIO_256;
				default: ratio = rate_conversion_core_pkg::RATIO_NONE;
			endcase
			`CHECK(o_power_down, 1'b0)
			`CHECK(o_port_role_select, 3'(m))
			`CHECK(o_ref_clk_ratio, ratio)
			`CHECK(o_out_port_master, 1'(!m[2] && m[1:0] != 0))
			`CHECK(o_in_port_master, 1'(m[2] && m[1:0] != 0))
		end
	endtask

	task automatic t_burst_write();
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_FILTER}, 32'h03b6_1020, 4);
		settle();
		`CHECK(o_buffer_depth, rate_conversion_core_pkg::DEPTH_SHORT)
		`CHECK(o_direct_downsample_sel, 1'b1)
		`CHECK(o_short_buffer_sel, 1'b1)
		`CHECK(o_left_atten_level, 8'h00)
		`CHECK(o_out_format, 2'h0)
		strobe();
		`CHECK(o_out_word_length, 2'h2)
		`CHECK(o_out_format, 2'h3)
		`CHECK(o_in_format, 3'h6)
		`CHECK(o_left_atten_level, 8'h10)
		`CHECK(o_right_atten_level, 8'h20)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_FILTER}, 32'h0000_0000, 1);
		settle();
		`CHECK(o_buffer_depth, rate_conversion_core_pkg::DEPTH_NORMAL)
		`CHECK(o_direct_downsample_sel, 1'b0)
	endtask

	task automatic t_track_mute();
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_00c0, 1);
		settle();
		strobe();
		`CHECK(o_right_atten_level, 8'h10)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0090, 1);
		settle();
		strobe();
		`CHECK(o_right_atten_level, 8'h20)
		`CHECK(o_soft_mute, 1'b1)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0080, 1);
		i_mute_pin = 1'b1;
		settle();
		strobe();
		`CHECK(o_soft_mute, 1'b1)
		i_mute_pin = 1'b0;
		settle();
		strobe();
		`CHECK(o_soft_mute, 1'b0)
	endtask

	task automatic t_bypass();
		i_bypass_pin = 1'b1;
		i_mute_pin = 1'b1;
		settle();
		strobe();
		`CHECK(o_convert_skip, 1'b1)
		`CHECK(o_dither_en, 1'b0)
		`CHECK(o_soft_mute, 1'b0)
		`CHECK(o_left_atten_level, 8'h00)
		i_bypass_pin = 1'b0;
		i_mute_pin = 1'b0;
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0088, 1);
		settle();
		strobe();
		`CHECK(o_convert_skip, 1'b1)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0080, 1);
		settle();
		strobe();
		`CHECK(o_convert_skip, 1'b0)
		`CHECK(o_dither_en, 1'b1)
		`CHECK(o_left_atten_level, 8'h10)
		`CHECK(o_right_atten_level, 8'h20)
		// Clock enable low freezes the boundary logic and the pin synchronisers
		i_clk_en = 1'b0;
		i_bypass_pin = 1'b1;
		settle();
		strobe();
		`CHECK(o_convert_skip, 1'b0)
		i_bypass_pin = 1'b0;
		settle();
		i_clk_en = 1'b1;
		settle();
	endtask

	task automatic t_refused_power();
		host.send_frame({2'b01, rate_conversion_core_pkg::ADDR_LEFT}, 32'h0000_0077, 1);
		settle();
		strobe();
		`CHECK(o_left_atten_level, 8'h10)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0000, 1);
		settle();
		strobe();
		`CHECK(o_power_down, 1'b1)
		`CHECK(o_left_atten_level, 8'h10)
		host.send_frame({2'b00, rate_conversion_core_pkg::ADDR_SYSTEM}, 32'h0000_0080, 1);
		settle();
		`CHECK(o_power_down, 1'b0)
		// Reset in mid-run brings written levels back to zero
		i_rst_n = 1'b0;
		@(negedge i_ref_clk);
		`CHECK(o_power_down, 1'b1)
		`CHECK(o_left_atten_level, 8'h00)
		`CHECK(o_right_atten_level, 8'h00)
		i_rst_n = 1'b1;
		settle();
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_mute_pin = 1'b0;
		i_bypass_pin = 1'b0;
		i_sample_strobe = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		t_reset_values();
		i_rst_n = 1'b1;
		for (int i = 0; i < 100 && o_spi_ready !== 1'b1; i++)
			@(negedge i_ref_clk);
		`CHECK(o_spi_ready, 1'b1)
		t_port_modes();
		t_burst_write();
		t_track_mute();
		t_bypass();
		t_refused_power();
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
